// ==== hw/qpd_decoder.sv ====
`timescale 1ns/1ps
module qpd_decoder #(
  parameter int unsigned NV_WRITE_CYC = qpd_pkg::NV_WRITE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        ce_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic [3:0]  device_select_bits_i,
  output logic [23:0]      wiper_o,
  output logic             nv_busy_o
);
  localparam int unsigned CW = $clog2(NV_WRITE_CYC + 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_A, ST_INSTR, ST_ACK_I, ST_STEP, ST_SKIP
  } qpd_state_t;

  // Returns the queued command for an instruction opcode nibble, none for step or unknown opcodes.
  function automatic qpd_pkg::qpd_cmd_t qpd_decode(input logic [3:0] op);
    case (op)
      qpd_pkg::OP_SAVE_ONE: qpd_decode = qpd_pkg::CMD_SAVE_ONE;
      qpd_pkg::OP_RECALL:   qpd_decode = qpd_pkg::CMD_RECALL;
      qpd_pkg::OP_SAVE_ALL: qpd_decode = qpd_pkg::CMD_SAVE_ALL;
      default:              qpd_decode = qpd_pkg::CMD_NONE;
    endcase
  endfunction

  logic [1:0] scl_s_r, sda_s_r;
  logic [3:0] adr_s1_r, adr_s2_r;
  logic       scl_d_r, sda_d_r;

  qpd_state_t       state_r, state_nxt;
  logic [3:0]       bits_r, bits_nxt;
  logic [7:0]       shift_r, shift_nxt;
  logic             ack_r, ack_nxt;
  logic             step_bit_r, step_bit_nxt;
  logic [1:0]       pot_r, pot_nxt;
  logic [1:0]       sel_r, sel_nxt;
  qpd_pkg::qpd_cmd_t cmd_r, cmd_nxt;
  logic             boot_r, boot_nxt;
  logic [CW-1:0]    nvcnt_r, nvcnt_nxt;
  logic             busy_r, busy_nxt;
  logic [3:0][5:0]  wiper_r, wiper_nxt;
  logic [5:0]       stored_r [16];
  logic [5:0]       stored_nxt [16];

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;

  // Two-stage synchronisers for pins; edge detection looks at stage two only.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      scl_s_r  <= 2'h3;
      sda_s_r  <= 2'h3;
      adr_s1_r <= 4'h0;
      adr_s2_r <= 4'h0;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_s_r  <= {scl_s_r[0], scl_i};
      sda_s_r  <= {sda_s_r[0], sda_i};
      adr_s1_r <= device_select_bits_i;
      adr_s2_r <= adr_s1_r;
      scl_d_r  <= scl_s_r[1];
      sda_d_r  <= sda_s_r[1];
    end
  end

  // Bus events seen on the synchronised lines.
  assign scl      = scl_s_r[1];
  assign sda      = sda_s_r[1];
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  assign start_c  = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_c   = scl & scl_d_r & ~sda_d_r & sda;

  // Frame sequencing, command execution and register updates.
  always_comb
  begin
    state_nxt    = state_r;
    bits_nxt     = bits_r;
    shift_nxt    = shift_r;
    ack_nxt      = ack_r;
    step_bit_nxt = step_bit_r;
    pot_nxt      = pot_r;
    sel_nxt      = sel_r;
    cmd_nxt      = cmd_r;
    boot_nxt     = 1'b0;
    nvcnt_nxt    = nvcnt_r;
    wiper_nxt    = wiper_r;
    for (int i = 0; i < 16; i++)
      stored_nxt[i] = stored_r[i];
    if (nvcnt_r != '0)
      nvcnt_nxt = nvcnt_r - 1'b1;
    if (boot_r)
    begin
      for (int p = 0; p < 4; p++)
        wiper_nxt[p] = stored_r[{2'(p), 2'h0}];  // R11
    end
    if (start_c)
    begin
      state_nxt = ST_ADDR;  // R1
      bits_nxt  = 4'h0;
      ack_nxt   = 1'b0;
      cmd_nxt   = qpd_pkg::CMD_NONE;
    end
    else if (stop_c)
    begin
      state_nxt = ST_IDLE;
      ack_nxt   = 1'b0;
      cmd_nxt   = qpd_pkg::CMD_NONE;
      case (cmd_r)
        qpd_pkg::CMD_SAVE_ONE:
        begin
          stored_nxt[{pot_r, sel_r}] = wiper_r[pot_r];  // R3
          nvcnt_nxt = CW'(NV_WRITE_CYC);  // R10
        end
        qpd_pkg::CMD_RECALL:
        begin
          for (int p = 0; p < 4; p++)
            wiper_nxt[p] = stored_r[{2'(p), sel_r}];  // R7
        end
        qpd_pkg::CMD_SAVE_ALL:
        begin
          for (int p = 0; p < 4; p++)
            stored_nxt[{2'(p), sel_r}] = wiper_r[p];  // R8
          nvcnt_nxt = CW'(NV_WRITE_CYC);  // R10
        end
        default: ;
      endcase
    end
    else
    begin
      case (state_r)
        ST_ADDR, ST_INSTR:
        begin
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda};
            bits_nxt  = bits_r + 4'h1;
          end
          else if (scl_fall && bits_r == qpd_pkg::BITS_BYTE)
          begin
            if (state_r == ST_ADDR)
            begin
              if (shift_r[7:4] == qpd_pkg::TYPE_CODE && shift_r[3:0] == adr_s2_r
                  && !busy_r)  // R1
              begin
                ack_nxt   = 1'b1;  // R2
                state_nxt = ST_ACK_A;
              end
              else
                state_nxt = ST_SKIP;  // R12
            end
            else if (shift_r[7:4] == qpd_pkg::OP_STEP
                     || qpd_decode(shift_r[7:4]) != qpd_pkg::CMD_NONE)
            begin
              ack_nxt   = 1'b1;  // R2
              state_nxt = ST_ACK_I;
              pot_nxt   = shift_r[1:0];  // R9
              sel_nxt   = shift_r[3:2];  // R9
            end
            else
              state_nxt = ST_SKIP;
          end
        end
        ST_ACK_A:
        begin
          if (scl_fall)
          begin
            ack_nxt   = 1'b0;
            bits_nxt  = 4'h0;
            state_nxt = ST_INSTR;
          end
        end
        ST_ACK_I:
        begin
          if (scl_fall)
          begin
            ack_nxt = 1'b0;
            if (shift_r[7:4] == qpd_pkg::OP_STEP)
              state_nxt = ST_STEP;  // R4
            else
            begin
              cmd_nxt   = qpd_decode(shift_r[7:4]);
              state_nxt = ST_SKIP;
            end
          end
        end
        ST_STEP:
        begin
          // The bit sampled on the rise is applied on the fall, so a stop never steps.
          if (scl_rise)
            step_bit_nxt = sda;
          else if (scl_fall)
          begin
            if (step_bit_r && wiper_r[pot_r] != qpd_pkg::WIPER_MAX)
              wiper_nxt[pot_r] = wiper_r[pot_r] + 6'h01;  // R5
            else if (!step_bit_r && wiper_r[pot_r] != 6'h00)
              wiper_nxt[pot_r] = wiper_r[pot_r] - 6'h01;  // R6
          end
        end
        default: ;
      endcase
    end
    busy_nxt = (nvcnt_nxt != '0);
  end

  // Registers the frame, wiper and stored state.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_r    <= ST_IDLE;
      bits_r     <= 4'h0;
      shift_r    <= 8'h00;
      ack_r      <= 1'b0;
      step_bit_r <= 1'b0;
      pot_r      <= 2'h0;
      sel_r      <= 2'h0;
      cmd_r      <= qpd_pkg::CMD_NONE;
      boot_r     <= 1'b1;
      nvcnt_r    <= '0;
      busy_r     <= 1'b0;
      wiper_r    <= '0;
      for (int i = 0; i < 16; i++)
        stored_r[i] <= qpd_pkg::STORED_RST;
    end
    else if (ce_i)
    begin
      state_r    <= state_nxt;
      bits_r     <= bits_nxt;
      shift_r    <= shift_nxt;
      ack_r      <= ack_nxt;
      step_bit_r <= step_bit_nxt;
      pot_r      <= pot_nxt;
      sel_r      <= sel_nxt;
      cmd_r      <= cmd_nxt;
      boot_r     <= boot_nxt;
      nvcnt_r    <= nvcnt_nxt;
      busy_r     <= busy_nxt;
      wiper_r    <= wiper_nxt;
      for (int i = 0; i < 16; i++)
        stored_r[i] <= stored_nxt[i];
    end
  end

  // Acknowledge pulls the data line low; it is never driven high.
  assign sda_o     = 1'b0;
  assign sda_oe_o  = ack_r;
  assign wiper_o   = wiper_r;
  assign nv_busy_o = busy_r;
endmodule // qpd_decoder

// ==== hw/qpd_pkg.sv ====
// Behaviour
// (R1) Frame opens with start, four-bit type code, four address bits; match required.
// (R2) Slave acknowledges each byte the master writes; master acknowledges bytes it reads. Code: no acknowledge for unknown opcodes or during a write cycle.
// (R3) Opcode 1110 copies chosen pot wiper into chosen stored register, write after stop.
// (R4) Opcode 0010, 00, pot pair, acknowledge, then step bits ended by stop.
// (R5) Step bit high moves selected wiper up one position.
// (R6) Step bit low moves selected wiper down one position.
// (R7) Opcode 0001 loads all wipers from chosen stored register at stop.
// (R8) Opcode 1000 saves all wipers into chosen stored register, write after stop.
// (R9) Unused bit positions are ignored by the device.
// (R10) Stored register writes complete within 10 ms of starting.
// (R11) Wipers are six-bit counters loaded from stored register zero at power-up.
// (R12) Non-matching frames get no acknowledge and change nothing until next start.
package qpd_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned NV_WRITE_MS = 10;
  // Longest time rounds down to whole cycles.
  localparam int unsigned NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);
  localparam int unsigned WIPER_W     = 6;
  localparam int unsigned POTS        = 4;
  localparam int unsigned STORED_PER  = 4;
  localparam logic [5:0]  STORED_RST  = 6'h00;
  localparam logic [5:0]  WIPER_MAX   = 6'h3F;
  // Device type code; the value is arbitrary.
  localparam logic [3:0]  TYPE_CODE   = 4'h9;
  localparam logic [3:0]  OP_SAVE_ONE = 4'hE;
  localparam logic [3:0]  OP_STEP     = 4'h2;
  localparam logic [3:0]  OP_RECALL   = 4'h1;
  localparam logic [3:0]  OP_SAVE_ALL = 4'h8;
  localparam logic [3:0]  BITS_BYTE   = 4'h8;
  typedef enum logic [1:0] {CMD_NONE, CMD_SAVE_ONE, CMD_RECALL, CMD_SAVE_ALL} qpd_cmd_t;
endpackage

// ==== verification/qpd_monitor.sv ====
`timescale 1ns/1ps
module qpd_monitor #(
  parameter int unsigned NV_WRITE_CYC = 20
) (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        ce_i,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic [3:0]  device_select_bits_i,
  input wire logic [23:0] wiper_o,
  input wire logic        nv_busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  int unsigned busy_cnt_r;
  int unsigned busy_cnt_nxt;
  sequence ack_rise;
    $rose(sda_oe_o);
  endsequence
  sequence ack_hold;
    sda_oe_o [*8] ##[1:32] !sda_oe_o;
  endsequence
  // Counts the cycles that a stored write has been running.
  always_comb busy_cnt_nxt = nv_busy_o ? busy_cnt_r + 1 : 0;
  // Registers the write cycle count.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      busy_cnt_r <= 0;
    else if (ce_i)
      busy_cnt_r <= busy_cnt_nxt;
  end
  AST_SDA_LOW: assert property (sda_o == 1'b0)
    else $error("data drive value not low");
  AST_ACK_SCL: assert property (ack_rise |-> !scl_i)
    else $error("acknowledge began with clock high");
  AST_ACK_LEN: assert property (ack_rise |-> ack_hold)
    else $error("acknowledge length wrong");
  AST_WIPER_QUIET: assert property ($changed(wiper_o) |-> !sda_oe_o)
    else $error("wiper moved during acknowledge");
  AST_BUSY_IDLE: assert property ($rose(nv_busy_o) |-> scl_i && sda_i)
    else $error("write cycle began outside idle bus");
  AST_BUSY_REFUSE: assert property (nv_busy_o && $past(nv_busy_o) |-> !$rose(sda_oe_o))
    else $error("acknowledge during write cycle");
  AST_BUSY_LEN: assert property ($fell(nv_busy_o) |-> busy_cnt_r == NV_WRITE_CYC)
    else $error("write cycle length wrong");
  AST_RESET: assert property (disable iff (1'b0) !rstn_i |=> !sda_oe_o && !nv_busy_o && wiper_o == 24'h0)
    else $error("reset state wrong");
endmodule // qpd_monitor

// ==== verification/qpd_master.sv ====
`timescale 1ns/1ps
module qpd_master (
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  // Both lines are released while the bus is idle.
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Data falls while the clock is high.
  task automatic start();
    sda_o = 1'b1; #40; scl_o = 1'b1; #40; sda_o = 1'b0; #80; scl_o = 1'b0; #40;
  endtask
  // Data changes only while the clock is low.
  task automatic bit_out(input logic b);
    sda_o = b; #40; scl_o = 1'b1; #80; scl_o = 1'b0; #40;
  endtask
  // Sends a byte MSB first, then samples the slave acknowledge.
  task automatic send(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    sda_o = 1'b1; #40; scl_o = 1'b1; #40; ack = ~sda_i; #40; scl_o = 1'b0; #40;
  endtask
  // Data rises while the clock is high, then the bus rests.
  task automatic stop();
    sda_o = 1'b0; #40; scl_o = 1'b1; #80; sda_o = 1'b1; #80;
  endtask
endmodule // qpd_master

// ==== verification/qpd_decoder_test.sv ====
`timescale 1ns/1ps
bind qpd_decoder qpd_monitor #(.NV_WRITE_CYC(NV_WRITE_CYC)) MON (.clk_i(clk_i), .rstn_i(rstn_i),
  .ce_i(ce_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .device_select_bits_i(device_select_bits_i), .wiper_o(wiper_o), .nv_busy_o(nv_busy_o));
module qpd_decoder_test;
  logic        clk_i = 0;
  logic        rstn_i = 0;
  logic [3:0]  sel = 4'h0;
  logic        ce = 1'b1;
  logic [7:0]  adr;
  logic        ack;
  wire         scl, sda_m, sda_d, oe, busy;
  wire  [23:0] wiper;
  wire         sda_w = sda_m & (~oe | sda_d);  // The device shows its drive value while enabled.
  int          error_cnt = 0, num_checks = 0, p;
  int          wm[4], sm[4][4];
  always #5 clk_i = ~clk_i;
  qpd_master MST (.sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
  qpd_decoder #(.NV_WRITE_CYC(400)) DUT (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(oe), .device_select_bits_i(sel),
    .wiper_o(wiper), .nv_busy_o(busy));
  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] mw();
    return {6'(wm[3]), 6'(wm[2]), 6'(wm[1]), 6'(wm[0])};
  endfunction
  task automatic cmd(input logic [7:0] a, input logic [7:0] ins, input bit ea, input bit ei);
    MST.start();
    MST.send(a, ack);
    check(24'(ack), 24'(ea));
    if (ea) MST.send(ins, ack);
    if (ea) check(24'(ack), 24'(ei));
  endtask
  task automatic steps(input int q, input int n, input bit up);
    logic b;
    repeat (n)
    begin
      b = up | 1'($urandom_range(1));
      MST.bit_out(b);
      wm[q] = b ? (wm[q] < 63 ? wm[q] + 1 : 63) : (wm[q] > 0 ? wm[q] - 1 : 0);
    end
  endtask
  // Lets a command land and any write cycle end, then compares the wipers.
  task automatic idle();
    repeat (10) @(negedge clk_i);
    for (int i = 0; i < 500 && busy !== 1'b0; i++) @(negedge clk_i);
    check(wiper, mw());
  endtask
  // Watchdog against a hung run.
  initial
  begin
    #900_000;
    error_cnt++;
    finish_test();
  end
  // Main sequence.
  initial
  begin
    void'($urandom(56));
    sel = 4'($urandom());
    adr = {qpd_pkg::TYPE_CODE, sel};
    repeat (5) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (5) @(negedge clk_i);
    check(wiper, 24'h0);
    for (int k = 0; k < 6; k++)
    begin
      p = $urandom_range(3);
      cmd(adr, {qpd_pkg::OP_STEP, 2'b00, 2'(p)}, 1, 1);
      steps(p, k == 5 ? 66 : $urandom_range(9, 1), k == 5);
      MST.stop();
      idle();
    end
    for (int r = 0; r < 4; r++)
    begin
      p = $urandom_range(3);
      cmd(adr, {qpd_pkg::OP_SAVE_ONE, 2'(r), 2'(p)}, 1, 1);
      MST.stop();
      sm[p][r] = wm[p];
      cmd(adr, 8'h21, 0, 0);
      MST.stop();
      idle();
      cmd(adr, {qpd_pkg::OP_SAVE_ALL, 2'(r ^ 1), 2'b00}, 1, 1);
      MST.stop();
      for (int q = 0; q < 4; q++) sm[q][r ^ 1] = wm[q];
      // Holding the enable low freezes the write cycle beyond its normal length.
      if (r == 0)
      begin
        ce = 1'b0;
        repeat (500) @(negedge clk_i);
        check(24'(busy), 24'h1);
        ce = 1'b1;
      end
      idle();
      cmd(adr, {qpd_pkg::OP_STEP, 2'b00, 2'(p)}, 1, 1);
      steps(p, 5, 0);
      MST.stop();
      idle();
      cmd(adr, {qpd_pkg::OP_RECALL, 2'(r), 2'b11}, 1, 1);
      MST.stop();
      for (int q = 0; q < 4; q++) wm[q] = sm[q][r];
      idle();
    end
    cmd({qpd_pkg::TYPE_CODE, ~sel}, 8'h21, 0, 0);
    // A step instruction inside a foreign frame must stay unanswered and inert.
    MST.send(8'h21, ack);
    check(24'(ack), 24'h0);
    repeat (4) MST.bit_out(1'b1);
    MST.stop();
    idle();
    cmd({~qpd_pkg::TYPE_CODE, sel}, 8'h21, 0, 0);
    MST.stop();
    cmd(adr, 8'hF1, 1, 0);
    repeat (4) MST.bit_out(1'b0);
    MST.stop();
    idle();
    finish_test();
  end
endmodule // qpd_decoder_test
